/* File: verilog/abu_defs.vh */
// constants for the immediate and single-bit operation unit
`ifndef ABU_DEFS_VH
`define ABU_DEFS_VH

// ----------------------------------------------------------------------
// instruction groups (upper five bits) and opcodes (upper eight bits of the word)
// ----------------------------------------------------------------------
`define ABU_GRP_IMM        5'h1e
`define ABU_GRP_BIT        5'h1f
`define ABU_LOAD_IMM_B     16'hf000
`define ABU_LOAD_IMM_A     16'hf100
`define ABU_LOAD_IMM_T     16'hf200
`define ABU_LOAD_IMM_X     16'hf300
`define ABU_ADD_IMM_A      16'hf500
`define ABU_ADD_IMM_T      16'hf600
`define ABU_ADD_IMM_X      16'hf700

// ----------------------------------------------------------------------
// instruction field positions
// ----------------------------------------------------------------------
`define ABU_IMM_MSB        7
`define ABU_TGT_LSB        8
`define ABU_TGT_MSB        9
`define ABU_ADD_SEL_BIT    10
`define ABU_SUB_MSB        10
`define ABU_SUB_LSB        7
`define ABU_IDX_MSB        6
`define ABU_IDX_LSB        3
`define ABU_SEL_MSB        2
`define ABU_SEL_LSB        0

// ----------------------------------------------------------------------
// target register codes (destination encoding)
// ----------------------------------------------------------------------
`define ABU_DR_STATUS      3'h0
`define ABU_DR_B           3'h3
`define ABU_DR_A           3'h5
`define ABU_DR_T           3'h6
`define ABU_DR_X           3'h7

// ----------------------------------------------------------------------
// status register flag positions
// ----------------------------------------------------------------------
`define ABU_PAGE_TABLE_MODE_FLAG   0
`define ABU_ROUNDING_FLAG          1
`define ABU_ACCUMULATOR_FLAG       2
`define ABU_ERROR_FLAG             3
`define ABU_DYNAMIC_OVERFLOW_FLAG  4
`define ABU_STATIC_OVERFLOW_FLAG   5
`define ABU_CARRY_FLAG             6
`define ABU_MULTISHIFT_LINK_FLAG   7

// ----------------------------------------------------------------------
// bit-operation sub-instruction codes
// ----------------------------------------------------------------------
`define ABU_SKIP_ZERO      4'h0
`define ABU_SKIP_ONE       4'h1
`define ABU_SKIP_INV_ACC   4'h2
`define ABU_SKIP_ACC       4'h3
`define ABU_WRITE_ZERO     4'h4
`define ABU_WRITE_ONE      4'h5
`define ABU_WRITE_INV      4'h6
`define ABU_WRITE_ACC      4'h7
`define ABU_STORE_ACC_CLR  4'h8
`define ABU_STORE_INV_SET  4'h9
`define ABU_LOAD_ACC       4'ha
`define ABU_LOAD_ACC_INV   4'hb
`define ABU_AND_INV_ACC    4'hc
`define ABU_OR_INV_ACC     4'hd
`define ABU_AND_ACC        4'he
`define ABU_OR_ACC         4'hf

// ----------------------------------------------------------------------
// register map (byte addresses) and reset values
// ----------------------------------------------------------------------
`define ABU_OFS_INSTR      8'h00
`define ABU_OFS_STATUS     8'h04
`define ABU_OFS_RESULT     8'h08
`define ABU_OFS_GPR_BASE   8'h20
`define ABU_RST_STATUS     8'h00
`define ABU_RST_GPR        16'h0000

`endif

/* File: verilog/abu_bitop.v */
// single-bit operation evaluator for the bit-operation group
`default_nettype none
`include "abu_defs.vh"

module abu_bitop
(
   // operands
   input  wire [3:0] sub_op,
   input  wire       bit_in,
   input  wire       acc_in,
   // results
   output reg        bit_out,
   output reg        bit_we,
   output reg        acc_out,
   output reg        acc_we,
   output reg        skip
);

   // decode the sub-instruction into bit, accumulator and skip effects
   always @*
   begin
      bit_out = bit_in;
      bit_we  = 1'b0;
      acc_out = acc_in;
      acc_we  = 1'b0;
      skip    = 1'b0;
      case (sub_op)
         `ABU_SKIP_ZERO     : skip = ~bit_in;
         `ABU_SKIP_ONE      : skip = bit_in;
         `ABU_SKIP_INV_ACC  : skip = (~bit_in) == acc_in;
         `ABU_SKIP_ACC      : skip = bit_in == acc_in;
         `ABU_WRITE_ZERO    :
         begin
            bit_out = 1'b0;
            bit_we  = 1'b1;
         end
         `ABU_WRITE_ONE     :
         begin
            bit_out = 1'b1;
            bit_we  = 1'b1;
         end
         `ABU_WRITE_INV     :
         begin
            bit_out = ~bit_in;
            bit_we  = 1'b1;
         end
         `ABU_WRITE_ACC     :
         begin
            bit_out = acc_in;
            bit_we  = 1'b1;
         end
         `ABU_STORE_ACC_CLR :
         begin
            bit_out = acc_in;
            bit_we  = 1'b1;
            acc_out = 1'b0;
            acc_we  = 1'b1;
         end
         `ABU_STORE_INV_SET :
         begin
            bit_out = ~acc_in;
            bit_we  = 1'b1;
            acc_out = 1'b1;
            acc_we  = 1'b1;
         end
         `ABU_LOAD_ACC      :
         begin
            acc_out = bit_in;
            acc_we  = 1'b1;
         end
         `ABU_LOAD_ACC_INV  :
         begin
            acc_out = ~bit_in;
            acc_we  = 1'b1;
         end
         `ABU_AND_INV_ACC   :
         begin
            acc_out = ~bit_in & acc_in;
            acc_we  = 1'b1;
         end
         `ABU_OR_INV_ACC    :
         begin
            acc_out = ~bit_in | acc_in;
            acc_we  = 1'b1;
         end
         `ABU_AND_ACC       :
         begin
            acc_out = bit_in & acc_in;
            acc_we  = 1'b1;
         end
         default            :
         begin
            acc_out = bit_in | acc_in;
            acc_we  = 1'b1;
         end
      endcase
   end

endmodule
`default_nettype wire

/* File: verilog/abu_unit.v */
// immediate and single-bit operation execution unit with apb access
//
// Functional notes
// - low eight instruction bits are a signed operand, -128 to 127.
// - bits 9:8 pick B, A, T or X; bit 10 picks load or add.
// - load opcodes 170000,170400,171000,171400 octal replace the target.
// - add opcodes 172400,173000,173400 octal add operand to the target.
// - loaded operand is sign extended into bits 8 to 15.
// - immediate addition wraps, extra result bits are dropped.
// - add sets carry and overflow flags like the register add.
// - bit ops: sub-op bits 10:7, bit index 6:3, register 2:0.
// - register selector zero means status register, else general register.
// - bit index field selects bit 0 to 15.
// - sixteen bit sub-ops: four skips, four writes, eight accumulator.
// - status exposes eight flags including the one-bit accumulator.
// - skip when bit is 0, is 1, inverted equals acc, or equals acc.
// - write bit with zero, one, its inverse, or the accumulator.
// - store-clear writes acc then clears; store-inv-set writes ~acc, sets.
// - acc takes bit, ~bit, and/or with acc, or ~bit and/or with acc.
`default_nettype none
`include "abu_defs.vh"

module abu_unit
(
   // clock, reset, enable
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   // instruction port from the decoder
   input  wire        instr_valid,
   input  wire [15:0] instr_word,
   // execution results
   output reg         done_r,
   output reg         skip_r,
   output reg  [7:0]  status_r,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);

   // ----------------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------------

   // sign extend the eight-bit operand to sixteen bits
   function [15:0] sext8;
      input [7:0] v;
      begin
         sext8 = {{8{v[`ABU_IMM_MSB]}}, v};
      end
   endfunction

   // map the two-bit target field onto a destination code
   function [2:0] tgt_code;
      input [1:0] f;
      begin
         case (f)
            2'h0    : tgt_code = `ABU_DR_B;
            2'h1    : tgt_code = `ABU_DR_A;
            2'h2    : tgt_code = `ABU_DR_T;
            default : tgt_code = `ABU_DR_X;
         endcase
      end
   endfunction

   // true when the apb address names a general register 1 to 7
   function is_gpr;
      input [7:0] a;
      begin
         is_gpr = ({a[7:5], 5'h00} == `ABU_OFS_GPR_BASE)
                  && (a[1:0] == 2'h0) && (a[4:2] != 3'h0);
      end
   endfunction

   // true when the instruction word belongs to the given group code
   function in_group;
      input [15:0] w;
      input [4:0]  g;
      begin
         in_group = w[15:11] == g;
      end
   endfunction

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   reg  [15:0] gpr [1:7];
   reg         pend_r;
   reg  [15:0] pend_word_r;
   integer     i;

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   // a transfer commits at the edge that samples pready high
   wire        apb_access = psel & penable;
   wire        apb_commit = apb_access & pready;
   wire        apb_wr     = apb_commit & pwrite;
   wire [2:0]  apb_gidx   = paddr[4:2];
   wire        hit_instr  = paddr == `ABU_OFS_INSTR;
   wire        hit_status = paddr == `ABU_OFS_STATUS;
   wire        hit_result = paddr == `ABU_OFS_RESULT;
   wire        hit_gpr    = is_gpr(paddr);
   wire        mapped     = hit_instr | hit_status | hit_result | hit_gpr;

   // ----------------------------------------------------------------------
   // instruction selection: decoder first, then a queued apb instruction
   // ----------------------------------------------------------------------
   // the decoder has priority; a queued word waits for a free cycle
   wire        fire      = instr_valid | pend_r;
   wire [15:0] word      = instr_valid ? instr_word : pend_word_r;
   wire        grp_imm   = in_group(word, `ABU_GRP_IMM);
   wire        grp_bit   = in_group(word, `ABU_GRP_BIT);

   // ----------------------------------------------------------------------
   // immediate group datapath
   // ----------------------------------------------------------------------
   // carry is bit 16 of the sum; overflow when like signs give unlike
   wire [15:0] imm_val   = sext8(word[`ABU_IMM_MSB:0]);
   wire [2:0]  imm_tgt   = tgt_code(word[`ABU_TGT_MSB:`ABU_TGT_LSB]);
   wire [15:0] imm_old   = gpr[imm_tgt];
   wire [16:0] imm_sum   = {1'b0, imm_old} + {1'b0, imm_val};
   wire        imm_ovf   = (imm_old[15] == imm_val[15])
                           && (imm_sum[15] != imm_old[15]);
   reg         is_load;
   reg         is_add;

   // recognise the documented load and add opcodes
   always @*
   begin
      is_load = 1'b0;
      is_add  = 1'b0;
      if (grp_imm)
      begin
         case ({word[15:8], 8'h00})
            `ABU_LOAD_IMM_B,
            `ABU_LOAD_IMM_A,
            `ABU_LOAD_IMM_T,
            `ABU_LOAD_IMM_X : is_load = 1'b1;
            `ABU_ADD_IMM_A,
            `ABU_ADD_IMM_T,
            `ABU_ADD_IMM_X  : is_add  = 1'b1;
            default         : is_add  = word[`ABU_ADD_SEL_BIT];
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // bit-operation group datapath
   // ----------------------------------------------------------------------
   // status bits 8 to 15 read as zero and ignore writes
   wire [3:0]  bop_sub   = word[`ABU_SUB_MSB:`ABU_SUB_LSB];
   wire [3:0]  bop_idx   = word[`ABU_IDX_MSB:`ABU_IDX_LSB];
   wire [2:0]  bop_sel   = word[`ABU_SEL_MSB:`ABU_SEL_LSB];
   wire        to_status = bop_sel == `ABU_DR_STATUS;
   wire [15:0] bop_src   = to_status ? {8'h00, status_r} : gpr[bop_sel];
   wire        bop_bit   = bop_src[bop_idx];
   wire        acc       = status_r[`ABU_ACCUMULATOR_FLAG];
   wire        bop_new;
   wire        bop_we;
   wire        acc_new;
   wire        acc_we;
   wire        bop_skip;

   // sixteen sub-instructions evaluated in one place
   abu_bitop u_bitop
   (
      .sub_op  (bop_sub),
      .bit_in  (bop_bit),
      .acc_in  (acc),
      .bit_out (bop_new),
      .bit_we  (bop_we),
      .acc_out (acc_new),
      .acc_we  (acc_we),
      .skip    (bop_skip)
   );

   // ----------------------------------------------------------------------
   // next status value: apb write, then instruction effects on top
   // ----------------------------------------------------------------------
   reg  [7:0]  status_nxt;

   // instruction effects override a same-cycle software write
   always @*
   begin
      status_nxt = status_r;
      if (apb_wr && hit_status)
         status_nxt = pwdata[7:0];
      if (fire && grp_imm && is_add)
      begin
         status_nxt[`ABU_CARRY_FLAG]            = imm_sum[16];
         status_nxt[`ABU_DYNAMIC_OVERFLOW_FLAG] = imm_ovf;
         if (imm_ovf)
            status_nxt[`ABU_STATIC_OVERFLOW_FLAG] = 1'b1;
      end
      if (fire && grp_bit)
      begin
         if (bop_we && to_status && !bop_idx[3])
            status_nxt[bop_idx[2:0]] = bop_new;
         if (acc_we)
            status_nxt[`ABU_ACCUMULATOR_FLAG] = acc_new;
      end
   end

   // ----------------------------------------------------------------------
   // register file and status update
   // ----------------------------------------------------------------------

   // general registers and status flags
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (i = 1; i < 8; i = i + 1)
            gpr[i] <= `ABU_RST_GPR;
         status_r <= `ABU_RST_STATUS;
      end
      else if (ce)
      begin
         if (apb_wr && hit_gpr)
            gpr[apb_gidx] <= pwdata[15:0];
         if (fire && is_load)
            gpr[imm_tgt] <= imm_val;
         else if (fire && is_add)
            gpr[imm_tgt] <= imm_sum[15:0];
         else if (fire && grp_bit && bop_we && !to_status)
            gpr[bop_sel][bop_idx] <= bop_new;
         status_r <= status_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // execution result outputs
   // ----------------------------------------------------------------------

   // one-cycle done and skip pulses after each executed instruction
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_r <= 1'b0;
         skip_r <= 1'b0;
      end
      else if (ce)
      begin
         done_r <= fire && (grp_imm || grp_bit);
         skip_r <= fire && grp_bit && bop_skip;
      end
   end

   // last skip decision kept for software
   reg         last_skip_r;

   // sticky until the next bit instruction executes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         last_skip_r <= 1'b0;
      else if (ce && fire && grp_bit)
         last_skip_r <= bop_skip;
   end

   // ----------------------------------------------------------------------
   // queued apb instruction
   // ----------------------------------------------------------------------

   // an apb instruction waits while the decoder issues and runs in the next cycle without one
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_r      <= 1'b0;
         pend_word_r <= 16'h0000;
      end
      else if (ce)
      begin
         if (apb_wr && hit_instr)
         begin
            pend_r      <= 1'b1;
            pend_word_r <= pwdata[15:0];
         end
         else if (!instr_valid)
            pend_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // apb read mux
   // ----------------------------------------------------------------------
   reg  [31:0] rd_data;

   // unmapped addresses read zero
   always @*
   begin
      rd_data = 32'h0000_0000;
      if (hit_instr)
         rd_data = {15'h0000, pend_r, pend_word_r};
      else if (hit_status)
         rd_data = {24'h00_0000, status_r};
      else if (hit_result)
         rd_data = {31'h0000_0000, last_skip_r};
      else if (hit_gpr)
         rd_data = {16'h0000, gpr[apb_gidx]};
   end

   // ----------------------------------------------------------------------
   // apb handshake: one wait state, then a registered answer
   // ----------------------------------------------------------------------

   // pready rises in the second access cycle and falls after completion
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (apb_access && !pready)
         begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= pwrite ? 32'h0000_0000 : rd_data;
         end
         else
         begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
         end
      end
   end

endmodule
`default_nettype wire

/* File: test/abu_unit_chk.sv */
// assertion checker for the immediate and single-bit operation unit
`default_nettype none
module abu_unit_chk
(
   // clock, reset and enable
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   // instruction port
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   // results
   input wire logic        done_r,
   input wire logic        skip_r,
   input wire logic [7:0]  status_r,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic       st_q;
   logic [3:0] sub_q;
   logic [3:0] idx_q;
   logic [7:0] prev_q;
   logic       exp_bit;
   logic       exp_acc;
   logic       exp_skip;
   wire        st_op = ce && instr_valid && instr_word[15:11] == 5'h1f &&
                       instr_word[2:0] == 3'h0 && !instr_word[6];
   wire        bq    = prev_q[idx_q[2:0]];
   wire        kq    = prev_q[2];

   // remember a status bit operation and the flags before it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q   <= 1'b0;
         sub_q  <= 4'h0;
         idx_q  <= 4'h0;
         prev_q <= 8'h00;
      end
      else
      begin
         st_q   <= st_op;
         sub_q  <= instr_word[10:7];
         idx_q  <= instr_word[6:3];
         prev_q <= status_r;
      end
   end

   // expected outcome of the remembered operation
   always_comb
   begin
      exp_bit  = bq;
      exp_acc  = kq;
      exp_skip = 1'b0;
      case (sub_q)
         4'h0: exp_skip = !bq;
         4'h1: exp_skip = bq;
         4'h2: exp_skip = (!bq == kq);
         4'h3: exp_skip = (bq == kq);
         4'h4: exp_bit = 1'b0;
         4'h5: exp_bit = 1'b1;
         4'h6: exp_bit = !bq;
         4'h7: exp_bit = kq;
         4'h8: exp_bit = kq;
         4'h9: exp_bit = !kq;
         4'ha: exp_acc = bq;
         4'hb: exp_acc = !bq;
         4'hc: exp_acc = !bq & kq;
         4'hd: exp_acc = !bq | kq;
         4'he: exp_acc = bq & kq;
         default: exp_acc = bq | kq;
      endcase
      if (sub_q == 4'h8)
         exp_acc = 1'b0;
      if (sub_q == 4'h9)
         exp_acc = 1'b1;
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   chk_done_group: assert property (
      ce && instr_valid && instr_word[15:12] == 4'hf |=> done_r)
      else $error("no done after a group instruction");
   chk_done_other: assert property (
      ce && instr_valid && instr_word[15:12] != 4'hf |=> !done_r)
      else $error("done after a foreign instruction");
   chk_skip_done: assert property (skip_r |-> done_r)
      else $error("skip without done");
   chk_skip_test: assert property (
      st_q && !sub_q[3] && !sub_q[2] |-> skip_r == exp_skip)
      else $error("skip decision wrong");
   chk_bit_write: assert property (
      st_q && sub_q >= 4'h4 && sub_q <= 4'h9 &&
      !(sub_q >= 4'h7 && idx_q == 4'h2) |-> status_r[idx_q[2:0]] == exp_bit)
      else $error("written bit wrong");
   chk_acc_update: assert property (
      st_q && sub_q[3] |-> status_r[2] == exp_acc)
      else $error("accumulator wrong");
   chk_pready_wait: assert property (
      ce && psel && !penable |=> !pready ##1 pready)
      else $error("apb answer timing wrong");
   chk_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   chk_err_unmapped: assert property (
      pready && paddr == 8'h20 |-> pslverr)
      else $error("no error on unmapped address");
endmodule

bind abu_unit abu_unit_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .instr_valid(instr_valid), .instr_word(instr_word), .done_r(done_r),
   .skip_r(skip_r), .status_r(status_r), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: test/tb.sv */
// self-checking testbench of the immediate and single-bit operation unit
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
   mismatches++; $display("wrong value at %0t: got %h expected %h", \
   $time, got, exp); end end

   logic        pclk, presetn, ce, instr_valid;
   logic [15:0] instr_word;
   logic        done_r, skip_r;
   logic [7:0]  status_r;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [31:0] r;
   logic        er;
   logic [15:0] m_gpr [0:7];
   logic [7:0]  m_st;
   logic        m_skip, e_done, e_skip;
   int          mismatches, cmp_count;

   abu_unit dut (.pclk(pclk), .presetn(presetn), .ce(ce),
      .instr_valid(instr_valid), .instr_word(instr_word), .done_r(done_r),
      .skip_r(skip_r), .status_r(status_r), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // 100 MHz clock
   always #5 pclk = ~pclk;

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one apb transfer, answer taken at the completing edge
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // pready and the answer are taken as they stand at the rising edge
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         mismatches++;
         close_out();
      end
      r = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                         input logic ee);
      apb(1'b0, a, 32'h0);
      `CHK(r, e)
      `CHK(er, ee)
   endtask

   // expected effect of one instruction word on the model
   function automatic void predict(input logic [15:0] w);
      logic [2:0]  t;
      logic [15:0] imm;
      logic [16:0] sum;
      logic        b, k, nb, nk;
      logic [3:0]  sub, idx;
      logic [2:0]  sel;
      e_done = 1'b0;
      e_skip = 1'b0;
      imm = {{8{w[7]}}, w[7:0]};
      sub = w[10:7]; idx = w[6:3]; sel = w[2:0];
      if (w[15:11] == 5'h1e)
      begin
         e_done = 1'b1;
         t = (w[9:8] == 2'h0) ? 3'h3 : 3'h4 + {1'b0, w[9:8]};
         sum = {1'b0, m_gpr[t]} + {1'b0, imm};
         if (!w[10])
            m_gpr[t] = imm;
         else
         begin
            m_st[6] = sum[16];
            m_st[4] = m_gpr[t][15] == imm[15] && sum[15] != imm[15];
            m_st[5] = m_st[5] | m_st[4];
            m_gpr[t] = sum[15:0];
         end
      end
      else if (w[15:11] == 5'h1f)
      begin
         e_done = 1'b1;
         k = m_st[2];
         b = (sel != 3'h0) ? m_gpr[sel][idx] : !idx[3] && m_st[idx[2:0]];
         nb = b;
         nk = k;
         case (sub)
            4'h0: e_skip = !b;
            4'h1: e_skip = b;
            4'h2: e_skip = (!b == k);
            4'h3: e_skip = (b == k);
            4'h4: nb = 1'b0;
            4'h5: nb = 1'b1;
            4'h6: nb = !b;
            4'h7, 4'h8: nb = k;
            4'h9: nb = !k;
            4'ha: nk = b;
            4'hb: nk = !b;
            4'hc: nk = !b & k;
            4'hd: nk = !b | k;
            4'he: nk = b & k;
            default: nk = b | k;
         endcase
         if (sub == 4'h8)
            nk = 1'b0;
         if (sub == 4'h9)
            nk = 1'b1;
         if (sel != 3'h0)
            m_gpr[sel][idx] = nb;
         else if (!idx[3])
            m_st[idx[2:0]] = nb;
         if (sub[3])
            m_st[2] = nk;
         m_skip = e_skip;
      end
   endfunction

   // issue one word for one cycle and check the results
   task automatic exec(input logic [15:0] w, input logic cev);
      @(posedge pclk);
      ce <= cev; instr_valid <= 1'b1; instr_word <= w;
      @(posedge pclk);
      ce <= 1'b1; instr_valid <= 1'b0;
      e_done = 1'b0;
      e_skip = 1'b0;
      if (cev)
         predict(w);
      @(negedge pclk);
      `CHK(done_r, e_done)
      `CHK(skip_r, e_skip)
      `CHK(status_r, m_st)
   endtask

   task automatic check_regs();
      for (int n = 1; n < 8; n++)
         rd_chk(8'h20 + 8'(4 * n), {16'h0, m_gpr[n]}, 1'b0);
      rd_chk(8'h04, {24'h0, m_st}, 1'b0);
      rd_chk(8'h08, {31'h0, m_skip}, 1'b0);
   endtask

   // main sequence
   initial
   begin
      logic [15:0] w;
      pclk = 0; presetn = 0; ce = 1; instr_valid = 0; instr_word = 0;
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      mismatches = 0; cmp_count = 0; m_st = 0; m_skip = 0;
      for (int n = 0; n < 8; n++)
         m_gpr[n] = 16'h0;
      void'($urandom(3));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      check_regs();
      rd_chk(8'h20, 32'h0, 1'b1);
      apb(1'b1, 8'h08, 32'h1); // result is read-only
      rd_chk(8'h08, 32'h0, 1'b0);
      apb(1'b1, 8'h04, 32'hffff_ff5a);
      m_st = 8'h5a;
      apb(1'b1, 8'h3c, 32'h0000_7fff);
      m_gpr[7] = 16'h7fff;
      exec(16'hf701, 1'b1);
      apb(1'b1, 8'h2c, 32'h0000_ffff);
      m_gpr[3] = 16'hffff;
      exec(16'hf401, 1'b1);
      exec(16'hf1a0, 1'b1);
      exec(16'hf27f, 1'b1);
      apb(1'b1, 8'h00, 32'h0000_f205); // queued load of T
      predict(16'hf205);
      repeat (2) @(negedge pclk);
      `CHK(done_r, e_done)
      rd_chk(8'h00, 32'h0000_f205, 1'b0);
      check_regs();
      for (int s = 0; s < 16; s++)
         exec({5'h1f, 4'(s), 4'h6, 3'h0}, 1'b1);
      exec(16'hf105, 1'b0); // frozen while enable is low
      for (int i = 0; i < 300; i++)
      begin
         w = 16'($urandom);
         case ($urandom % 4)
            0: w[15] = 1'b0;
            1: w[15:11] = 5'h1e;
            default: w[15:11] = 5'h1f;
         endcase
         if (w[15:11] == 5'h1f && $urandom % 2)
            w[2:0] = 3'h0;
         exec(w, 1'b1);
         if (i % 50 == 49)
            check_regs();
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      m_st = 0; m_skip = 0;
      for (int n = 0; n < 8; n++)
         m_gpr[n] = 16'h0;
      check_regs();
      close_out();
   end
endmodule
`default_nettype wire
